// [inc/slt_pkg.sv]
package slt_pkg;

	// Lane and field geometry
	localparam int NLANES = 4;
	localparam int CTRL_W = 7;
	localparam int TCTL_W = 6;
	localparam int EV_W   = 5;

	// Register indices; byte address is four times the index
	localparam logic [11:0] IX_TEST_EN   = 12'h315;
	localparam logic [11:0] IX_TEST_CTRL = 12'h316;
	localparam logic [11:0] IX_THR_LO    = 12'h317;
	localparam logic [11:0] IX_THR_MID   = 12'h318;
	localparam logic [11:0] IX_THR_HI    = 12'h319;
	localparam logic [11:0] IX_CNT_LO    = 12'h31a;
	localparam logic [11:0] IX_CNT_MID   = 12'h31b;
	localparam logic [11:0] IX_CNT_HI    = 12'h31c;
	localparam logic [11:0] IX_PASS      = 12'h31d;
	localparam logic [11:0] IX_TPL_CTRL  = 12'h32c;
	localparam logic [11:0] IX_REF_LO    = 12'h32d;
	localparam logic [11:0] IX_REF_HI    = 12'h32e;
	localparam logic [11:0] IX_TPL_RES   = 12'h32f;
	localparam logic [11:0] IX_INV       = 12'h334;
	localparam logic [11:0] IX_IRQ_STAT  = 12'h340;
	localparam logic [11:0] IX_IRQ_CLR   = 12'h341;
	localparam logic [11:0] IX_IRQ_EN    = 12'h342;
	localparam logic [11:0] IX_DID       = 12'h400;
	localparam logic [11:0] IX_BID       = 12'h401;

	// Field positions
	localparam int CTRL_CLR_BIT = 0;
	localparam int CTRL_RUN_BIT = 1;
	localparam int CTRL_PAT_LSB = 2;
	localparam int CTRL_SRC_LSB = 4;
	localparam int TPL_EN_BIT   = 0;
	localparam int TPL_CLR_BIT  = 1;
	localparam int TPL_DAC_LSB  = 2;
	localparam int TPL_SP_LSB   = 4;
	localparam int EV_TPL_BIT   = 4;

	// Reset values
	localparam logic [3:0] PASS_RST = 4'hf;

	// Pattern codes
	localparam logic [1:0] PAT_PRBS7  = 2'h0;
	localparam logic [1:0] PAT_PRBS15 = 2'h1;
	localparam logic [1:0] PAT_PRBS31 = 2'h2;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [15:0] paddr;
		logic [31:0] pwdata;
	} slt_apb_t;

	typedef struct packed {
		logic                  valid;
		logic [3:0][3:0][15:0] smp;
	} slt_tpl_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] did;
		logic [3:0] adj;
		logic [3:0] bid;
	} slt_ilas_t;

endpackage

// [design/slt_top.sv]
`timescale 1ns/1ns
`default_nettype none

// Function
// RULE1: Threshold bits 7:0 sit in their own writable register.
// RULE2: Threshold middle byte gives bits 15:8, top byte bits 23:16.
// RULE3: Selected lane's 24-bit error count reads over three byte registers.
// RULE4: Three-bit source field picks the lane shown in the count registers.
// RULE5: Pattern code 00 PRBS7, 01 PRBS15, 10 PRBS31, 11 reserved.
// RULE6: Test runs on enabled lanes while started; test clear resets state.
// RULE7: Per-lane pass flag is 1 while count below threshold; 0xF after reset.
// RULE8: Each mismatching bit adds one to the count, which saturates.
// RULE9: Sample comparison happens only while its enable bit is 1.
// RULE10: Two-bit field picks the DAC channel of the compared sample.
// RULE11: Two-bit field picks the sample position within that channel.
// RULE12: Expected sample is built from low and high bytes and compared.
// RULE13: Result bit reads 0 on match and 1 on mismatch.
// RULE14: Result clear bit at 1 clears the result; at 0 leaves it.
// RULE15: Per logical lane invert bit flips every deserialized data bit.
// RULE16: Device identifier received on lane 0 reads back as eight bits.
// RULE17: Adjust resolution received on lane 0 reads in bits 7:4.
// RULE18: Bank identifier received on lane 0 reads in bits 3:0.
// RULE19: Transmitter sends the selected pattern for the whole test.
module slt_top
	import slt_pkg::*;
#(
	parameter int W = 32
) (
	input  wire logic                  clock,
	input  wire logic                  srst,
	input  wire slt_apb_t              apb,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [3:0]            lane_valid,
	input  wire logic [3:0][W-1:0]     lane_data,
	output logic [3:0][W-1:0]          lane_out,
	input  wire slt_tpl_t              tpl,
	input  wire slt_ilas_t             ilas,
	output logic [3:0]                 lane_pass_flags,
	output logic                       compare_mismatch_flag,
	output logic                       irq
);

	localparam int CW = $clog2(W + 1);

	// Word width the bit-serial checker can serve
	if (W < 1 || W > 256) begin : g_bad_w
		$error("slt_top: W must lie in 1..256");
	end

	typedef struct packed {
		logic [3:0]            test_en;
		logic [CTRL_W-1:0]     ctrl;
		logic [23:0]           thr;
		logic [3:0][23:0]      cnt;
		logic [3:0][30:0]      hist;
		logic [3:0]            pass;
		logic [TCTL_W-1:0]     tctl;
		logic [15:0]           ref_s;
		logic                  fail;
		logic [3:0]            inv;
		logic [3:0][W-1:0]     lout;
		logic [7:0]            did;
		logic [7:0]            bid;
		logic [EV_W-1:0]       ist;
		logic [EV_W-1:0]       ien;
		logic [31:0]           rdata;
		logic                  perr;
	} slt_state_t;

	localparam slt_state_t S_RST = '{pass: PASS_RST, default: '0};

	slt_state_t            s_reg;
	slt_state_t            s_next;
	logic                  clr;
	logic                  run;
	logic [1:0]            pat;
	logic [2:0]            src;
	logic                  t_en;
	logic                  t_clr;
	logic [1:0]            dac;
	logic [1:0]            sp;
	logic [15:0]           smp;
	logic [11:0]           idx;
	logic                  setup;
	logic                  wr;
	logic [32:0]           rd;
	logic [EV_W-1:0]       ev;
	logic [CW+30:0]        chk;
	logic [24:0]           sum;
	logic [W-1:0]          din;

	// Checks one word bit by bit against the selected polynomial
	function automatic logic [CW+30:0] prbs_chk(
		input logic [30:0]  h,
		input logic [W-1:0] d,
		input logic [1:0]   p
	);
		logic [30:0]   hh;
		logic [CW-1:0] n;
		logic          e;
		hh = h;
		n  = '0;
		for (int i = 0; i < W; i++) begin
			case (p) // RULE5
				PAT_PRBS7:  e = hh[6] ^ hh[5];
				PAT_PRBS15: e = hh[14] ^ hh[13];
				PAT_PRBS31: e = hh[30] ^ hh[27];
				default:    e = d[i];
			endcase
			if (e != d[i]) begin
				n = n + 1'b1; // RULE8
			end
			hh = {hh[29:0], d[i]};
		end
		return {n, hh};
	endfunction

	// Register map: hit flag and read value for an index
	function automatic logic [32:0] reg_word(
		input slt_state_t st,
		input logic [11:0] ix,
		input logic [2:0]  sel
	);
		logic [23:0] c;
		c = (sel < 3'(NLANES)) ? st.cnt[sel[1:0]] : 24'h0; // RULE4
		case (ix)
			IX_TEST_EN:   return {1'b1, 28'h0, st.test_en};
			IX_TEST_CTRL: return {1'b1, 25'h0, st.ctrl};
			IX_THR_LO:    return {1'b1, 24'h0, st.thr[7:0]};
			IX_THR_MID:   return {1'b1, 24'h0, st.thr[15:8]};
			IX_THR_HI:    return {1'b1, 24'h0, st.thr[23:16]};
			IX_CNT_LO:    return {1'b1, 24'h0, c[7:0]};
			IX_CNT_MID:   return {1'b1, 24'h0, c[15:8]};
			IX_CNT_HI:    return {1'b1, 24'h0, c[23:16]};
			IX_PASS:      return {1'b1, 28'h0, st.pass};
			IX_TPL_CTRL:  return {1'b1, 26'h0, st.tctl};
			IX_REF_LO:    return {1'b1, 24'h0, st.ref_s[7:0]};
			IX_REF_HI:    return {1'b1, 24'h0, st.ref_s[15:8]};
			IX_TPL_RES:   return {1'b1, 31'h0, st.fail}; // RULE13
			IX_INV:       return {1'b1, 28'h0, st.inv};
			IX_IRQ_STAT:  return {1'b1, 27'h0, st.ist};
			IX_IRQ_CLR:   return {1'b1, 32'h0};
			IX_IRQ_EN:    return {1'b1, 27'h0, st.ien};
			IX_DID:       return {1'b1, 24'h0, st.did};
			IX_BID:       return {1'b1, 24'h0, st.bid};
			default:      return 33'h0;
		endcase
	endfunction

	// Control field decode
	assign clr   = s_reg.ctrl[CTRL_CLR_BIT];
	assign run   = s_reg.ctrl[CTRL_RUN_BIT] & ~clr;
	assign pat   = s_reg.ctrl[CTRL_PAT_LSB +: 2];
	assign src   = s_reg.ctrl[CTRL_SRC_LSB +: 3];
	assign t_en  = s_reg.tctl[TPL_EN_BIT];
	assign t_clr = s_reg.tctl[TPL_CLR_BIT];
	assign dac   = s_reg.tctl[TPL_DAC_LSB +: 2];
	assign sp    = s_reg.tctl[TPL_SP_LSB +: 2];
	assign smp   = tpl.smp[dac][sp]; // RULE10 RULE11

	// Bus phase decode
	assign setup = apb.psel & ~apb.penable;
	assign wr    = apb.psel & apb.penable & apb.pwrite;
	assign idx   = apb.paddr[13:2];
	assign rd    = reg_word(s_reg, idx, src);

	// Next-state logic
	always_comb begin
		s_next = s_reg;
		ev     = '0;
		chk    = '0;
		sum    = '0;
		din    = '0;
		// Lane inversion, checking and counting
		for (int i = 0; i < NLANES; i++) begin
			din = lane_data[i] ^ {W{s_reg.inv[i]}}; // RULE15
			chk = prbs_chk(s_reg.hist[i], din, pat);
			sum = {1'b0, s_reg.cnt[i]} + 25'(chk[CW+30:31]);
			if (lane_valid[i]) begin
				s_next.lout[i] = din;
			end
			if (clr) begin
				s_next.cnt[i]  = 24'h0; // RULE6
				s_next.hist[i] = 31'h0;
				s_next.pass[i] = PASS_RST[i];
			end else if (s_reg.test_en[i] && lane_valid[i]) begin
				// History always tracks so the first word counts truly
				s_next.hist[i] = chk[30:0]; // RULE19
				if (run) begin // RULE6
					s_next.cnt[i]  = sum[24] ? 24'hffffff : sum[23:0]; // RULE8
					s_next.pass[i] = s_next.cnt[i] < s_reg.thr; // RULE7
					ev[i]          = s_reg.pass[i] & ~s_next.pass[i];
				end
			end
		end
		// Transport-layer sample comparison
		if (t_clr) begin
			s_next.fail = 1'b0; // RULE14
		end else if (t_en && tpl.valid) begin // RULE9
			s_next.fail    = smp != s_reg.ref_s; // RULE12 RULE13
			ev[EV_TPL_BIT] = s_next.fail;
		end
		// Link configuration capture from lane 0
		if (ilas.valid) begin
			s_next.did = ilas.did; // RULE16
			s_next.bid = {ilas.adj, ilas.bid}; // RULE17 RULE18
		end
		// Register writes at the access edge
		if (wr && rd[32] && apb.paddr[1:0] == 2'h0 && apb.paddr[15:14] == 2'h0) begin
			case (idx)
				IX_TEST_EN:   s_next.test_en = apb.pwdata[3:0];
				IX_TEST_CTRL: s_next.ctrl = apb.pwdata[CTRL_W-1:0];
				IX_THR_LO:    s_next.thr[7:0] = apb.pwdata[7:0]; // RULE1
				IX_THR_MID:   s_next.thr[15:8] = apb.pwdata[7:0]; // RULE2
				IX_THR_HI:    s_next.thr[23:16] = apb.pwdata[7:0]; // RULE2
				IX_TPL_CTRL:  s_next.tctl = apb.pwdata[TCTL_W-1:0];
				IX_REF_LO:    s_next.ref_s[7:0] = apb.pwdata[7:0]; // RULE12
				IX_REF_HI:    s_next.ref_s[15:8] = apb.pwdata[7:0]; // RULE12
				IX_INV:       s_next.inv = apb.pwdata[3:0];
				IX_IRQ_CLR:   s_next.ist = s_reg.ist & ~apb.pwdata[EV_W-1:0];
				IX_IRQ_EN:    s_next.ien = apb.pwdata[EV_W-1:0];
				default:      ;
			endcase
		end
		// New events win over a clear in the same cycle
		s_next.ist = s_next.ist | ev;
		// Read data and error latched in the setup cycle
		if (setup) begin
			s_next.rdata = rd[31:0];
			s_next.perr  = ~rd[32] | (apb.paddr[1:0] != 2'h0) | (apb.paddr[15:14] != 2'h0);
		end
	end

	// State register
	always_ff @(posedge clock) begin
		if (srst) begin
			s_reg <= S_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs
	assign prdata                = s_reg.rdata;
	assign pready                = apb.psel & apb.penable;
	assign pslverr               = apb.psel & apb.penable & s_reg.perr;
	assign lane_out              = s_reg.lout;
	assign lane_pass_flags       = s_reg.pass; // RULE7
	assign compare_mismatch_flag = s_reg.fail;
	assign irq                   = |(s_reg.ist & s_reg.ien);

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	chk_thr_low_write: assert property ( // RULE1
		wr && apb.paddr == {2'h0, IX_THR_LO, 2'h0}
		|=> s_reg.thr[7:0] == $past(apb.pwdata[7:0]) && $stable(s_reg.thr[23:8]))
		else $error("threshold low byte not written");

	chk_thr_hi_write: assert property ( // RULE2
		wr && apb.paddr == {2'h0, IX_THR_HI, 2'h0}
		|=> s_reg.thr[23:16] == $past(apb.pwdata[7:0]) && $stable(s_reg.thr[15:0]))
		else $error("threshold high byte not written");

	chk_count_read: assert property ( // RULE3
		setup && apb.paddr == {2'h0, IX_CNT_MID, 2'h0} && src == 3'h1
		|=> prdata == {24'h0, $past(s_reg.cnt[1][15:8])})
		else $error("count middle byte read wrong");

	chk_count_hold: assert property ( // RULE6
		!run && !clr |=> $stable(s_reg.cnt))
		else $error("count moved while test stopped");

	chk_test_clear: assert property ( // RULE6
		clr |=> s_reg.cnt == '0 && s_reg.pass == PASS_RST)
		else $error("test clear did not reset state");

	chk_pass_level: assert property ( // RULE7
		$fell(s_reg.pass[0]) |-> s_reg.cnt[0] >= s_reg.thr)
		else $error("pass flag fell below threshold");

	chk_count_sat: assert property ( // RULE8
		s_reg.cnt[2] == 24'hffffff && !clr |=> s_reg.cnt[2] == 24'hffffff)
		else $error("error count wrapped");

	chk_cmp_result: assert property ( // RULE13
		t_en && !t_clr && tpl.valid |=> s_reg.fail == ($past(smp) != $past(s_reg.ref_s)))
		else $error("compare result wrong");

	chk_cmp_idle: assert property ( // RULE9
		!t_en && !t_clr |=> $stable(s_reg.fail))
		else $error("compare result moved while disabled");

	chk_cmp_clear: assert property ( // RULE14
		t_clr |=> !compare_mismatch_flag)
		else $error("result clear ignored");

	chk_id_capture: assert property ( // RULE16 RULE17 RULE18
		ilas.valid |=> s_reg.did == $past(ilas.did)
			&& s_reg.bid == {$past(ilas.adj), $past(ilas.bid)})
		else $error("lane 0 identifiers not captured");

	chk_lane_invert: assert property ( // RULE15
		lane_valid[3] |=> lane_out[3] == ($past(lane_data[3]) ^ {W{$past(s_reg.inv[3])}}))
		else $error("lane inversion wrong");

endmodule

`default_nettype wire

// [dv/slt_tx_model.sv]
`timescale 1ns/1ns
`default_nettype none

module slt_tx_model
	import slt_pkg::*;
#(
	parameter int W = 32
) (
	input  wire logic              clock,
	input  wire logic              srst,
	input  wire logic              en,
	input  wire logic              flip,
	input  wire logic [1:0]        pat,
	output logic [3:0]             lane_valid,
	output logic [3:0][W-1:0]      lane_data
);
	logic [30:0]  h = '1;

	initial lane_valid = 4'h0;
	initial lane_data = '0;

	// Selected PRBS words, bit 0 first; flip corrupts one bit of lane 0
	always @(posedge clock) begin : gen
		logic [30:0]  t;
		logic [W-1:0] w;
		t = h;
		w = '0;
		if (srst || !en) begin
			lane_valid <= 4'h0;
			lane_data  <= ~lane_data; // Idle lines do not hold a value
		end else begin
			for (int i = 0; i < W; i++) begin
				case (pat)
					PAT_PRBS15: w[i] = t[14] ^ t[13];
					PAT_PRBS31: w[i] = t[30] ^ t[27];
					default:    w[i] = t[6] ^ t[5];
				endcase
				t = {t[29:0], w[i]};
			end
			h          <= t;
			lane_valid <= 4'hf;
			lane_data  <= {w, w, w, w ^ {{(W-1){1'b0}}, flip}};
		end
	end
endmodule

`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	import slt_pkg::*;
	logic              clock = 1'b0;
	logic              srst = 1'b1;
	slt_apb_t          apb = '0;
	slt_tpl_t          tpl = '0;
	slt_ilas_t         ilas = '0;
	logic              en = 1'b0;
	logic              flip = 1'b0;
	logic [1:0]        pat = PAT_PRBS7;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic [3:0]        lane_valid;
	logic [3:0][31:0]  lane_data;
	logic [3:0][31:0]  lane_out;
	logic [3:0]        lane_pass_flags;
	logic              compare_mismatch_flag;
	logic              irq;
	logic [31:0]       rv;
	logic [31:0]       d0;
	logic [31:0]       d1;
	logic              ev;
	int                fail_count = 0;
	int                tests_run = 0;

	// 125 MHz clock
	always #4 clock = ~clock;

	slt_top #(.W(32)) slt_top_inst (.clock(clock), .srst(srst), .apb(apb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .lane_valid(lane_valid), .lane_data(lane_data),
		.lane_out(lane_out), .tpl(tpl), .ilas(ilas), .lane_pass_flags(lane_pass_flags),
		.compare_mismatch_flag(compare_mismatch_flag), .irq(irq));

	slt_tx_model #(.W(32)) slt_tx_model_inst (.clock(clock), .srst(srst), .en(en),
		.flip(flip), .pat(pat), .lane_valid(lane_valid), .lane_data(lane_data));

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
			fail_count++;
		end
	endtask

	// One APB transfer, setup then access until pready
	task automatic xfer(input logic wr, input logic [11:0] ix, input logic [31:0] wd);
		apb.psel    <= 1'b1;
		apb.penable <= 1'b0;
		apb.pwrite  <= wr;
		apb.paddr   <= {2'h0, ix, 2'h0};
		apb.pwdata  <= wd;
		@(posedge clock);
		apb.penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rv = prdata;
		ev = pslverr;
		apb.psel    <= 1'b0;
		apb.penable <= 1'b0;
		@(posedge clock);
	endtask

	task automatic wr(input logic [11:0] ix, input logic [31:0] d);
		xfer(1'b1, ix, d);
	endtask

	task automatic rc(input string nm, input logic [11:0] ix, input logic [31:0] exp);
		xfer(1'b0, ix, 32'h0);
		chk(nm, rv, exp);
	endtask

	task automatic pulse_flip;
		flip <= 1'b1;
		@(posedge clock);
		flip <= 1'b0;
		repeat (4) @(posedge clock);
	endtask

	task finish_test;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clock);
		fail_count++;
		finish_test;
	end

	// Main sequence
	initial begin
		repeat (8) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		rc("pass_rst", IX_PASS, 32'hf);
		rc("cnt_rst", IX_CNT_LO, 32'h0);
		wr(IX_PASS, 32'h0);
		rc("pass_ro", IX_PASS, 32'hf);
		xfer(1'b0, 12'h200, 32'h0);
		chk("unmapped_err", {31'h0, ev}, 32'h1);
		wr(IX_THR_LO, 32'h6);
		wr(IX_THR_MID, 32'ha5);
		wr(IX_THR_HI, 32'h5a);
		rc("thr_lo", IX_THR_LO, 32'h6);
		rc("thr_mid", IX_THR_MID, 32'ha5);
		rc("thr_hi", IX_THR_HI, 32'h5a);
		wr(IX_THR_MID, 32'h0);
		wr(IX_THR_HI, 32'h0);
		wr(IX_TEST_EN, 32'hf);
		en <= 1'b1;
		repeat (4) @(posedge clock);
		wr(IX_TEST_CTRL, 32'h02);
		rc("cnt_clean", IX_CNT_LO, 32'h0);
		// One flipped bit upsets three self-synchronised predictions
		pulse_flip;
		rc("cnt_one", IX_CNT_LO, 32'h3);
		rc("pass_below", IX_PASS, 32'hf);
		pulse_flip;
		rc("cnt_two", IX_CNT_LO, 32'h6);
		rc("cnt_mid", IX_CNT_MID, 32'h0);
		rc("pass_fail", IX_PASS, 32'he);
		chk("pass_port", {28'h0, lane_pass_flags}, 32'he);
		wr(IX_TEST_CTRL, 32'h12);
		rc("cnt_lane1", IX_CNT_LO, 32'h0);
		rc("cnt_lane1_mid", IX_CNT_MID, 32'h0);
		wr(IX_TEST_CTRL, 32'h00);
		pulse_flip;
		rc("cnt_stopped", IX_CNT_LO, 32'h6);
		wr(IX_TEST_CTRL, 32'h01);
		rc("cnt_clear", IX_CNT_LO, 32'h0);
		rc("pass_clear", IX_PASS, 32'hf);
		wr(IX_TEST_CTRL, 32'h0e);
		pulse_flip;
		rc("cnt_reserved", IX_CNT_LO, 32'h0);
		wr(IX_TEST_CTRL, 32'h01);
		// PRBS15 then PRBS31; history tracks before run is raised
		pat <= PAT_PRBS15;
		wr(IX_TEST_CTRL, 32'h04);
		wr(IX_TEST_CTRL, 32'h06);
		rc("cnt_p15_clean", IX_CNT_LO, 32'h0);
		pulse_flip;
		rc("cnt_p15_flip", IX_CNT_LO, 32'h3);
		wr(IX_TEST_CTRL, 32'h01);
		pat <= PAT_PRBS31;
		wr(IX_TEST_CTRL, 32'h08);
		wr(IX_TEST_CTRL, 32'h0a);
		rc("cnt_p31_clean", IX_CNT_LO, 32'h0);
		pulse_flip;
		rc("cnt_p31_flip", IX_CNT_LO, 32'h3);
		// A disabled lane neither checks nor counts
		wr(IX_TEST_EN, 32'he);
		pulse_flip;
		rc("cnt_lane_off", IX_CNT_LO, 32'h3);
		wr(IX_TEST_CTRL, 32'h01);
		wr(IX_TEST_EN, 32'hf);
		// Lane 0 inverted, lane 1 passed straight
		wr(IX_INV, 32'h1);
		@(posedge clock);
		d0 = lane_data[0];
		d1 = lane_data[1];
		@(posedge clock);
		chk("lane_out0", lane_out[0], ~d0);
		chk("lane_out1", lane_out[1], d1);
		// Short sample compare on channel 2, sample 3
		tpl.smp[2][3] <= 16'h1234;
		tpl.smp[3][2] <= 16'hffff;
		tpl.valid <= 1'b1;
		wr(IX_REF_LO, 32'h34);
		wr(IX_REF_HI, 32'h12);
		wr(IX_TPL_CTRL, 32'h39);
		repeat (3) @(posedge clock);
		chk("cmp_match", {31'h0, compare_mismatch_flag}, 32'h0);
		tpl.smp[2][3] <= 16'h1235;
		repeat (3) @(posedge clock);
		rc("cmp_miss", IX_TPL_RES, 32'h1);
		wr(IX_TPL_CTRL, 32'h38);
		tpl.smp[2][3] <= 16'h1234;
		repeat (3) @(posedge clock);
		chk("cmp_off", {31'h0, compare_mismatch_flag}, 32'h1);
		wr(IX_TPL_CTRL, 32'h3a);
		rc("cmp_clear", IX_TPL_RES, 32'h0);
		// Lane-0 link identifiers
		ilas <= '{valid: 1'b1, did: 8'ha5, adj: 4'h3, bid: 4'hc};
		@(posedge clock);
		ilas.valid <= 1'b0;
		rc("dev_id", IX_DID, 32'ha5);
		rc("adj_bank", IX_BID, 32'h3c);
		// Interrupt status, enable and clear
		rc("irq_stat", IX_IRQ_STAT, 32'h11);
		chk("irq_masked", {31'h0, irq}, 32'h0);
		wr(IX_IRQ_EN, 32'h10);
		chk("irq_on", {31'h0, irq}, 32'h1);
		wr(IX_IRQ_CLR, 32'h10);
		chk("irq_off", {31'h0, irq}, 32'h0);
		wr(IX_IRQ_CLR, 32'h01);
		rc("irq_clr", IX_IRQ_STAT, 32'h0);
		finish_test;
	end
endmodule

`default_nettype wire
